//--- rtl/phyreg_bank.sv
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module phyreg_bank
  import phyreg_pkg::*;
#(
  parameter logic [15:0] OUI_UPPER = OUI_UPPER_DEFAULT,
  parameter logic [5:0]  OUI_LOWER = OUI_LOWER_DEFAULT,
  parameter logic [5:0]  MODEL     = MODEL_DEFAULT,
  parameter logic [3:0]  REVISION  = REV_DEFAULT
)
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire phyreg_pkg::phyreg_req_t req,
  output var  logic [15:0]       rdata,
  input  wire phyreg_pkg::phyreg_phy_t phy_in,
  input  wire logic              page_valid,
  input  wire logic [15:0]       page_word,
  output var  logic [15:0]       advertisement_word
);
  import phyreg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin-side status synchronisers
  phyreg_phy_t sync1;
  phyreg_phy_t sync2;
  logic        page_sync1;
  logic        page_sync2;
  logic        page_prev;
  logic [15:0] word_sync1;
  logic [15:0] word_sync2;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync1      <= '0;
      sync2      <= '0;
      page_sync1 <= 1'b0;
      page_sync2 <= 1'b0;
      page_prev  <= 1'b0;
      word_sync1 <= 16'h0000;
      word_sync2 <= 16'h0000;
    end
    else
    begin
      sync1      <= phy_in;
      sync2      <= sync1;
      page_sync1 <= page_valid;
      page_sync2 <= page_sync1;
      page_prev  <= page_sync2;
      word_sync1 <= page_word;
      word_sync2 <= word_sync1;
    end
  end

  wire logic page_strobe = page_sync2 & ~page_prev;
  wire logic status_read = req.rd && (req.addr == OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Latching status flags; a new event wins over the read clear
  logic rfault_latch;
  logic link_latch;
  logic jabber_latch;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rfault_latch <= 1'b0;
      link_latch   <= 1'b0;
      jabber_latch <= 1'b0;
    end
    else
    begin
      if (sync2.remote_fault)
        rfault_latch <= 1'b1;
      else if (status_read)
        rfault_latch <= 1'b0;
      if (!sync2.link_ok)
        link_latch <= 1'b0;
      else if (status_read)
        link_latch <= 1'b1;
      if (sync2.jabber && sync2.ten_mode)
        jabber_latch <= 1'b1;
      else if (status_read)
        jabber_latch <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Advertisement word
  logic [15:0] adv_store;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      adv_store <= ADV_RESET;
    else if (req.wr && (req.addr == OFS_ADVERTISE))
      adv_store <= req.wdata & ADV_WRITE_MASK;
  end

  logic [15:0] adv_view;
  always_comb
  begin
    adv_view = adv_store;
    adv_view[ADV_NEXT_PAGE] = 1'b0;
    adv_view[ADV_FOUR_PAIR] = 1'b0;
    adv_view[4:0] = SELECTOR_VALUE;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      advertisement_word <= 16'h0000;
    else
      advertisement_word <= adv_view;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link partner ability, held between negotiations
  logic [15:0] partner;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      partner <= 16'h0000;
    else if (page_strobe)
      partner <= word_sync2 & LP_LOAD_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status view and read mux
  logic [15:0] status_view;
  always_comb
  begin
    status_view = 16'h0000;
    status_view[STS_FAST_FD]     = 1'b1;
    status_view[STS_FAST_HD]     = 1'b1;
    status_view[STS_TEN_FD]      = 1'b1;
    status_view[STS_TEN_HD]      = 1'b1;
    status_view[STS_NEG_DONE]    = sync2.neg_done;
    status_view[STS_RFAULT]      = rfault_latch;
    status_view[STS_NEG_CAPABLE] = 1'b1;
    status_view[STS_LINK]        = link_latch;
    status_view[STS_JABBER]      = jabber_latch;
    status_view[STS_EXTENDED]    = 1'b1;
  end

  logic [15:0] next_rdata;
  always_comb
  begin
    next_rdata = 16'h0000;
    if (!req.rd)
      next_rdata = 16'h0000;
    else if (req.addr == OFS_STATUS)
      next_rdata = status_view;
    else if (req.addr == OFS_ID_HIGH)
      next_rdata = OUI_UPPER;
    else if (req.addr == OFS_ID_LOW)
      next_rdata = {OUI_LOWER, MODEL, REVISION};
    else if (req.addr == OFS_ADVERTISE)
      next_rdata = adv_view;
    else if (req.addr == OFS_PARTNER)
      next_rdata = partner;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata <= 16'h0000;
    else
      rdata <= next_rdata;
  end

endmodule

`default_nettype wire

//--- rtl/phyreg_pkg.sv
package phyreg_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS     = 8'hb8;
  localparam logic [7:0] OFS_ID_HIGH    = 8'hbc;
  localparam logic [7:0] OFS_ID_LOW     = 8'hc0;
  localparam logic [7:0] OFS_ADVERTISE  = 8'hc4;
  localparam logic [7:0] OFS_PARTNER    = 8'hc8;

  // Status word field positions
  localparam int STS_FAST_FD     = 14;
  localparam int STS_FAST_HD     = 13;
  localparam int STS_TEN_FD      = 12;
  localparam int STS_TEN_HD      = 11;
  localparam int STS_NEG_DONE    = 5;
  localparam int STS_RFAULT      = 4;
  localparam int STS_NEG_CAPABLE = 3;
  localparam int STS_LINK        = 2;
  localparam int STS_JABBER      = 1;
  localparam int STS_EXTENDED    = 0;

  // Advertisement field positions
  localparam int ADV_NEXT_PAGE = 15;
  localparam int ADV_RFAULT    = 13;
  localparam int ADV_PAUSE     = 10;
  localparam int ADV_FOUR_PAIR = 9;
  localparam int ADV_FAST_FD   = 8;
  localparam int ADV_FAST_HD   = 7;
  localparam int ADV_TEN_FD    = 6;
  localparam int ADV_TEN_HD    = 5;

  // Writable advertisement bits and their reset value
  localparam logic [15:0] ADV_WRITE_MASK = 16'h25e0;
  localparam logic [15:0] ADV_RESET      = 16'h0060;
  localparam logic [4:0]  SELECTOR_VALUE = 5'h01;

  // Partner word: bits 15,14,13,10 and 9..0 are loaded
  localparam logic [15:0] LP_LOAD_MASK = 16'he7ff;

  // Identity defaults (arbitrary values)
  localparam logic [15:0] OUI_UPPER_DEFAULT = 16'h1234;
  localparam logic [5:0]  OUI_LOWER_DEFAULT = 6'h15;
  localparam logic [5:0]  MODEL_DEFAULT     = 6'h2a;
  localparam logic [3:0]  REV_DEFAULT       = 4'h3;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } phyreg_req_t;

  typedef struct packed {
    logic neg_done;
    logic link_ok;
    logic remote_fault;
    logic jabber;
    logic ten_mode;
  } phyreg_phy_t;

endpackage

//--- verification/phyreg_bank_chk.sv
`timescale 1ns/10ps
`default_nettype none
module phyreg_bank_chk
  import phyreg_pkg::*;
(
  input wire logic                    core_clk,
  input wire logic                    rst,
  input wire phyreg_pkg::phyreg_req_t req,
  input wire logic [15:0]             rdata,
  input wire phyreg_pkg::phyreg_phy_t phy_in
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic rs;
  assign rs = req.rd && req.addr == OFS_STATUS;
  property p_fix; rs |=> rdata[12:11] == 2'b11 && rdata[3] && rdata[0]; endproperty
  a_fix: assert property (p_fix) else $error("fixed bits");
  property p_neg; phy_in.neg_done [*5] ##0 rs |=> rdata[5]; endproperty
  a_neg: assert property (p_neg) else $error("neg done");
  property p_rf; phy_in.remote_fault [*5] ##0 rs |=> rdata[4]; endproperty
  a_rf: assert property (p_rf) else $error("fault");
  property p_lnk; !phy_in.link_ok [*5] ##0 rs |=> !rdata[2]; endproperty
  a_lnk: assert property (p_lnk) else $error("link");
  property p_jab; (phy_in.jabber && phy_in.ten_mode) [*5] ##0 rs |=> rdata[1]; endproperty
  a_jab: assert property (p_jab) else $error("jabber");
  property p_id1; req.rd && req.addr == OFS_ID_HIGH |=> rdata == OUI_UPPER_DEFAULT; endproperty
  a_id1: assert property (p_id1) else $error("id one");
  property p_id2; req.rd && req.addr == OFS_ID_LOW |=> rdata[9:4] == MODEL_DEFAULT; endproperty
  a_id2: assert property (p_id2) else $error("id two");
  property p_adv; req.rd && req.addr == OFS_ADVERTISE |=> !rdata[15] && !rdata[9] && rdata[4:0] == 5'h01; endproperty
  a_adv: assert property (p_adv) else $error("adv");
  c_rf: cover property (rs ##1 rdata[4]);
  c_lnk: cover property (rs ##1 rdata[2]);
  c_adv: cover property (req.wr && req.addr == OFS_ADVERTISE);
endmodule
bind phyreg_bank phyreg_bank_chk i_phyreg_bank_chk (.core_clk(core_clk), .rst(rst), .req(req), .rdata(rdata),
  .phy_in(phy_in));
`default_nettype wire

//--- verification/phyreg_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module phyreg_bank_tb_top;
  import phyreg_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  phyreg_req_t req = '0;
  phyreg_phy_t phy_in = '0;
  logic        page_valid = 1'b0;
  logic [15:0] page_word = 16'h0000;
  logic [15:0] rdata;
  logic [15:0] adv;
  int          n_mismatch = 0;
  int          comparisons = 0;
  always #12.5 core_clk = ~core_clk;
  phyreg_bank i_phyreg_bank (.core_clk(core_clk), .rst(rst), .req(req), .rdata(rdata), .phy_in(phy_in),
    .page_valid(page_valid), .page_word(page_word), .advertisement_word(adv));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge core_clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic t_regs;
    wr(OFS_STATUS, 16'h0000);
    rd(OFS_STATUS, 16'hffff, 16'h7809);
    rd(OFS_ID_HIGH, 16'hffff, 16'h1234);
    rd(OFS_ID_LOW, 16'hffff, 16'h56a3);
    rd(OFS_ADVERTISE, 16'hffff, 16'h0061);
    rd(OFS_PARTNER, 16'hffff, 16'h0000);
    rd(8'hd0, 16'hffff, 16'h0000);
    wr(OFS_ADVERTISE, 16'hffff);
    rd(OFS_ADVERTISE, 16'hffff, 16'h25e1);
    chk(adv, 16'h25e1);
    wr(OFS_ADVERTISE, 16'h0000);
    rd(OFS_ADVERTISE, 16'hffff, 16'h0001);
  endtask
  task automatic t_latch;
    phy_in <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    cyc(5);
    rd(OFS_STATUS, 16'h0020, 16'h0020);
    rd(OFS_STATUS, 16'h0036, 16'h0024);
    phy_in <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    cyc(5);
    phy_in <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    cyc(5);
    rd(OFS_STATUS, 16'h0036, 16'h0032);
    rd(OFS_STATUS, 16'h0036, 16'h0024);
  endtask
  task automatic t_partner(input logic [15:0] w, input logic [15:0] e);
    page_word <= w;
    cyc(5);
    page_valid <= 1'b1;
    cyc(8);
    page_valid <= 1'b0;
    page_word <= ~w;
    rd(OFS_PARTNER, 16'hffff, e);
  endtask
  task automatic print_verdict;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_latch();
    t_partner(16'hffff, 16'he7ff);
    t_partner(16'h4400, 16'h4400);
    print_verdict();
  end
  initial
  begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
